// ### rtl/adc_readout_defs.svh
// constants for the converter result readout block
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH
`define RESULT_BITS 24
`define RESULT_BYTES 3
`define CODE_BITS 17
`define DEVICE_ADDR_RESET 7'h14
`define OVER_FILL 16'h0000
`define UNDER_FILL 16'hFFFF
`define TAIL_BITS 6'h00
`define CONV_TIME_US 147000
`define CLK_MHZ 25
`define CONV_CYCLES (`CONV_TIME_US * `CLK_MHZ)
`endif

// ### rtl/adc_readout_pkg.sv
// types for the converter result readout block
package adc_readout_pkg;
    typedef enum {ST_CONVERT, ST_SLEEP, ST_OUTPUT} conv_state_type;
    typedef enum {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_DATA, BUS_DATA_ACK, BUS_IGNORE} bus_state_type;
    typedef struct packed {
        logic sign_flag;
        logic [15:0] magnitude;
    } code_type;
endpackage

// ### rtl/adc_result_i2c_readout.sv
// converter state cycle and transmit-only two-wire slave for the result word
// Behaviour
// - after reset cycle conversion, sleep, output, then conversion again
// - after conversion sleep and hold result until addressed for read
// - master sends seven address bits then direction, one means read
// - address match during conversion is refused by leaving data released
// - every matching write request is not-acknowledged
// - matching read outside conversion is acknowledged, then result transmitted
// - result word is 24 bits: two status bits, 16-bit value, six zero bits
// - device changes data after clock fall; master samples on rise
// - after three bytes, clear output, start conversion, refuse further reads
// - bit 23 is sign flag, one for zero or positive input
// - sign flag and bit 22 together encode the input range
// - overrange forces the following 16 bits to zero
// - underrange forces the following 16 bits to one
// - 16 two's complement bits follow status bits, then six zeros
// - out of range inputs clamp to full scale plus or minus one step
// - start and stop are detected from data edges while clock high
// - repeated start restarts address reception like a start
// - ninth clock is acknowledge; transmitter releases data line
// - data changes only while clock low except start and stop
// - lines only pulled low; clock is input only
// - link runs at any rate up to 400 kbit/s
// - stop during acknowledge clock aborts read and starts conversion
// - stop during data output ends output and starts conversion
`include "adc_readout_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_result_i2c_readout #(
    parameter int CONV_CYCLES = `CONV_CYCLES,
    parameter logic [6:0] DEVICE_ADDR = `DEVICE_ADDR_RESET
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // converter core
    input wire logic code_valid,
    input wire adc_readout_pkg::code_type code_in,
    input wire logic over_range,
    input wire logic under_range,
    // link
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status
    output logic converting,
    output logic sleeping,
    output logic outputting
);
    adc_readout_pkg::conv_state_type state_r;
    logic [31:0] conv_cnt_r;
    logic [23:0] result_r;
    logic [23:0] word_nxt;
    // link side
    adc_readout_pkg::bus_state_type bus_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [1:0] byte_cnt_r;
    logic [23:0] tx_r;
    logic [4:0] bit_idx;
    logic link_rst_r;
    logic start_tog_r;
    logic start_seen_r;
    logic start_pend;
    logic stop_tog_r;
    logic done_tog_r;
    logic ack_tog_r;
    logic [23:0] load_r;
    // crossings into link domain
    logic busy_q1_r;
    logic busy_q2_r;
    // crossings into clk domain
    logic [2:0] stop_s_r;
    logic [2:0] done_s_r;
    logic [2:0] ack_s_r;

    // result word assembly with range forcing
    always_comb begin
        word_nxt = {code_in.sign_flag, ~code_in.sign_flag, code_in.magnitude, `TAIL_BITS};
        if (over_range) begin
            word_nxt = {2'h3, `OVER_FILL, `TAIL_BITS};
        end else if (under_range) begin
            word_nxt = {2'h0, `UNDER_FILL, `TAIL_BITS};
        end else if (code_in.sign_flag) begin
            word_nxt = {2'h2, code_in.magnitude, `TAIL_BITS};
        end else begin
            word_nxt = {2'h1, code_in.magnitude, `TAIL_BITS};
        end
    end

    // cross link events into clk domain (toggles)
    always_ff @(posedge clk) begin
        if (rst) begin
            stop_s_r <= 3'h0;
            done_s_r <= 3'h0;
            ack_s_r <= 3'h0;
        end else begin
            stop_s_r <= {stop_s_r[1:0], stop_tog_r};
            done_s_r <= {done_s_r[1:0], done_tog_r};
            ack_s_r <= {ack_s_r[1:0], ack_tog_r};
        end
    end

    // one-cycle events from the link toggles
    logic ack_evt;
    logic done_evt;
    logic stop_evt;
    assign ack_evt = ack_s_r[2] != ack_s_r[1];
    assign done_evt = done_s_r[2] != done_s_r[1];
    assign stop_evt = stop_s_r[2] != stop_s_r[1];

    // converter state cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= adc_readout_pkg::ST_CONVERT;
            conv_cnt_r <= 32'h0;
            result_r <= 24'h0;
        end else begin
            case (state_r)
                adc_readout_pkg::ST_CONVERT: begin
                    conv_cnt_r <= conv_cnt_r + 32'h1;
                    if (conv_cnt_r >= 32'(CONV_CYCLES - 1) && code_valid) begin
                        state_r <= adc_readout_pkg::ST_SLEEP;
                        result_r <= word_nxt;
                        conv_cnt_r <= 32'h0;
                    end
                end
                adc_readout_pkg::ST_SLEEP: begin
                    if (ack_evt) begin
                        state_r <= adc_readout_pkg::ST_OUTPUT;
                    end
                end
                adc_readout_pkg::ST_OUTPUT: begin
                    if (done_evt || stop_evt) begin
                        state_r <= adc_readout_pkg::ST_CONVERT;
                        result_r <= 24'h0;
                    end
                end
                default: state_r <= adc_readout_pkg::ST_CONVERT;
            endcase
        end
    end

    // status outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            converting <= 1'h1;
            sleeping <= 1'h0;
            outputting <= 1'h0;
            load_r <= 24'h0;
        end else begin
            converting <= state_r == adc_readout_pkg::ST_CONVERT;
            sleeping <= state_r == adc_readout_pkg::ST_SLEEP;
            outputting <= state_r == adc_readout_pkg::ST_OUTPUT;
            load_r <= result_r; // held stable while sleeping, read by link
        end
    end

    // reset for the link side; its clock stands still while idle
    always_ff @(posedge clk) begin
        link_rst_r <= rst;
    end

    // data level is always low, only the enable pulls the line
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_out <= 1'h0;
        end else begin
            sda_out <= 1'h0;
        end
    end

    // busy level into link domain
    always_ff @(posedge scl_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            busy_q1_r <= 1'h1;
            busy_q2_r <= 1'h1;
        end else begin
            busy_q1_r <= converting;
            busy_q2_r <= busy_q1_r;
        end
    end

    // start: data falls while clock high
    always_ff @(negedge sda_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            start_tog_r <= 1'h0;
        end else if (scl_clk) begin
            start_tog_r <= ~start_tog_r;
        end
    end

    // stop: data rises while clock high
    always_ff @(posedge sda_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            stop_tog_r <= 1'h0;
        end else if (scl_clk) begin
            stop_tog_r <= ~stop_tog_r;
        end
    end

    assign start_pend = start_tog_r != start_seen_r;
    assign bit_idx = 5'h17 - {byte_cnt_r, 3'h0} - {1'h0, bit_cnt_r};

    // link domain: reception and acknowledge sampling on clock rise
    always_ff @(posedge scl_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            bus_r <= adc_readout_pkg::BUS_IDLE;
            start_seen_r <= 1'h0;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            byte_cnt_r <= 2'h0;
            tx_r <= 24'h000000;
            ack_tog_r <= 1'h0;
            done_tog_r <= 1'h0;
        end else if (start_pend) begin
            start_seen_r <= start_tog_r;
            bus_r <= adc_readout_pkg::BUS_ADDR;
            bit_cnt_r <= 4'h1;
            shift_r <= {7'h00, sda_in};
            byte_cnt_r <= 2'h0;
        end else begin
            case (bus_r)
                adc_readout_pkg::BUS_ADDR: begin
                    shift_r <= {shift_r[6:0], sda_in};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'h7) begin
                        if (shift_r[6:0] != DEVICE_ADDR) begin
                            bus_r <= adc_readout_pkg::BUS_IGNORE;
                        end else begin
                            bus_r <= adc_readout_pkg::BUS_ADDR_ACK;
                        end
                    end
                end
                adc_readout_pkg::BUS_ADDR_ACK: begin
                    bit_cnt_r <= 4'h0;
                    if (sda_oe) begin
                        bus_r <= adc_readout_pkg::BUS_DATA;
                        tx_r <= load_r;
                        ack_tog_r <= ~ack_tog_r;
                    end else begin
                        bus_r <= adc_readout_pkg::BUS_IGNORE;
                    end
                end
                adc_readout_pkg::BUS_DATA: begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == 4'h7) begin
                        bus_r <= adc_readout_pkg::BUS_DATA_ACK;
                    end
                end
                adc_readout_pkg::BUS_DATA_ACK: begin
                    bit_cnt_r <= 4'h0;
                    if (byte_cnt_r == 2'(`RESULT_BYTES - 1)) begin
                        done_tog_r <= ~done_tog_r;
                        bus_r <= adc_readout_pkg::BUS_IGNORE;
                    end else if (sda_in) begin
                        bus_r <= adc_readout_pkg::BUS_IGNORE;
                    end else begin
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        bus_r <= adc_readout_pkg::BUS_DATA;
                    end
                end
                adc_readout_pkg::BUS_IGNORE: begin
                    bus_r <= adc_readout_pkg::BUS_IGNORE;
                end
                adc_readout_pkg::BUS_IDLE: begin
                    bus_r <= adc_readout_pkg::BUS_IDLE;
                end
                default: bus_r <= adc_readout_pkg::BUS_IDLE;
            endcase
        end
    end

    // drive on falling clock edge only, so data changes while clock low
    always_ff @(negedge scl_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            sda_oe <= 1'h0;
        end else if (start_pend) begin
            sda_oe <= 1'h0;
        end else begin
            case (bus_r)
                adc_readout_pkg::BUS_ADDR_ACK: begin
                    sda_oe <= shift_r[0] && !busy_q2_r;
                end
                adc_readout_pkg::BUS_DATA: begin
                    sda_oe <= !tx_r[bit_idx];
                end
                adc_readout_pkg::BUS_DATA_ACK: begin
                    sda_oe <= 1'h0;
                end
                adc_readout_pkg::BUS_IGNORE: begin
                    sda_oe <= 1'h0;
                end
                adc_readout_pkg::BUS_ADDR: begin
                    sda_oe <= 1'h0;
                end
                adc_readout_pkg::BUS_IDLE: begin
                    sda_oe <= 1'h0;
                end
                default: begin
                    sda_oe <= 1'h0;
                end
            endcase
        end
    end
endmodule // adc_result_i2c_readout
`default_nettype wire

// ### sim/adc_result_i2c_readout_chk.sv
// assertion checker for the result readout block
`timescale 1ns/100ps
`default_nettype none
module adc_result_i2c_readout_chk (
    // system
    input wire logic clk,
    input wire logic rst,
    // converter core
    input wire logic code_valid,
    input wire adc_readout_pkg::code_type code_in,
    input wire logic over_range,
    input wire logic under_range,
    // link
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // status
    input wire logic converting,
    input wire logic sleeping,
    input wire logic outputting
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_ONE_STATE: assert property ($onehot({converting, sleeping, outputting}))
        else $error("state flags not one-hot");
    AST_DRIVE_LOW_ONLY: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    AST_CONV_TO_SLEEP: assert property ($fell(converting) |-> sleeping)
        else $error("conversion not followed by sleep");
    AST_SLEEP_TO_OUT: assert property ($fell(sleeping) |-> outputting)
        else $error("sleep not followed by output");
    AST_OUT_TO_CONV: assert property ($fell(outputting) |-> converting)
        else $error("output not followed by conversion");
    AST_BUSY_RELEASED: assert property (converting [*4] |-> !sda_oe)
        else $error("data line driven during conversion");
    AST_OUT_FROM_SLEEP: assert property ($rose(outputting) |-> $past(sleeping))
        else $error("output entered without sleep");
    AST_SLEEP_RELEASED: assert property ($rose(sleeping) |-> !sda_oe)
        else $error("data line driven on entering sleep");
endmodule // adc_result_i2c_readout_chk
`default_nettype wire

// ### sim/adc_result_i2c_readout_tb.sv
// testbench for the result readout block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module adc_result_i2c_readout_tb;
    localparam logic [6:0] ADDR = 7'h14;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic code_valid = 1'h1;
    logic over_range = 1'h1;
    logic under_range = 1'h0;
    adc_readout_pkg::code_type code_in = '0;
    wire logic scl_clk;
    wire logic m_oe;
    wire logic sda_line;
    logic sda_out, sda_oe, converting, sleeping, outputting;
    int err_total = 0;
    int check_count = 0;
    assign sda_line = !(sda_oe | m_oe);
    i2c_master_model m (.scl(scl_clk), .sda_drv(m_oe), .sda(sda_line));
    adc_result_i2c_readout #(.CONV_CYCLES(50), .DEVICE_ADDR(ADDR)) DUT (
        .clk(clk), .rst(rst), .code_valid(code_valid), .code_in(code_in),
        .over_range(over_range), .under_range(under_range), .scl_clk(scl_clk),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .converting(converting),
        .sleeping(sleeping), .outputting(outputting));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic addr(input logic [7:0] a, output logic ak);
        logic [7:0] rx;
        m.start();
        m.xfer(a, 1'h1, rx, ak);
    endtask
    task automatic rd(input logic last, output logic [7:0] b);
        logic ak;
        m.xfer(8'hFF, last, b, ak);
    endtask
    task automatic wait_sleep();
        repeat (200) if (sleeping !== 1'h1) @(negedge clk);
    endtask
    task automatic t_busy();
        logic ak;
        `CHK(converting, 1'h1)
        `CHK(sda_out, 1'h0)
        addr({ADDR, 1'h1}, ak);
        `CHK(ak, 1'h1)
        m.stop();
    endtask
    task automatic t_refuse();
        logic ak;
        wait_sleep();
        `CHK(sleeping, 1'h1)
        addr({ADDR, 1'h0}, ak);
        `CHK(ak, 1'h1)
        addr({ADDR ^ 7'h01, 1'h1}, ak);
        `CHK(ak, 1'h1)
        m.stop();
        `CHK(sleeping, 1'h1)
    endtask
    task automatic t_over();
        logic ak;
        logic [23:0] w;
        addr({ADDR, 1'h1}, ak);
        `CHK(ak, 1'h0)
        rd(1'h0, w[23:16]);
        `CHK(outputting, 1'h1)
        rd(1'h0, w[15:8]);
        rd(1'h1, w[7:0]);
        `CHK(w, 24'hC00000)
        addr({ADDR, 1'h1}, ak);
        `CHK(ak, 1'h1)
        m.stop();
        @(negedge clk);
        over_range = 1'h0;
        under_range = 1'h1;
        `CHK(converting, 1'h1)
    endtask
    task automatic t_under();
        logic ak;
        logic [23:0] w;
        wait_sleep();
        addr({ADDR, 1'h1}, ak);
        `CHK(ak, 1'h0)
        rd(1'h0, w[23:16]);
        m.byte8(8'hFF, w[15:8]);
        m.stop();
        @(negedge clk);
        under_range = 1'h0;
        code_in = {1'h1, 16'h1234};
        `CHK(w[23:8], 16'h3FFF)
        repeat (4) @(negedge clk);
        `CHK(converting, 1'h1)
    endtask
    task automatic t_norm();
        logic ak;
        logic [23:0] w;
        wait_sleep();
        addr({ADDR, 1'h1}, ak);
        `CHK(ak, 1'h0)
        rd(1'h0, w[23:16]);
        rd(1'h0, w[15:8]);
        rd(1'h1, w[7:0]);
        m.stop();
        `CHK(w[23:22], 2'h2)
        `CHK(w[5:0], 6'h00)
        `CHK(w[21:6], 16'h1234)
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'h0;
        t_busy();
        t_refuse();
        t_over();
        t_under();
        t_norm();
        results();
    end
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule // adc_result_i2c_readout_tb
bind adc_result_i2c_readout adc_result_i2c_readout_chk chk_i (
    .clk(clk), .rst(rst), .code_valid(code_valid), .code_in(code_in),
    .over_range(over_range), .under_range(under_range), .scl_clk(scl_clk),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .converting(converting),
    .sleeping(sleeping), .outputting(outputting));
`default_nettype wire

// ### sim/i2c_master_model.sv
// two-wire bus master model reading result words
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
    // link
    output var logic scl,
    output var logic sda_drv,
    input wire logic sda
);
    initial begin
        scl = 1'h1;
        sda_drv = 1'h0;
    end
    task automatic start();
        sda_drv = 1'h0;
        #16 scl = 1'h1;
        #32 sda_drv = 1'h1;
        #32 scl = 1'h0;
        #16;
    endtask
    task automatic stop();
        sda_drv = 1'h1;
        #16 scl = 1'h1;
        #32 sda_drv = 1'h0;
        #32;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_drv = !b;
        #16 scl = 1'h1;
        r = sda;
        #32 scl = 1'h0;
        #16;
    endtask
    task automatic byte8(input logic [7:0] tx, output logic [7:0] rx);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ak_out, output logic [7:0] rx,
                        output logic ak_in);
        byte8(tx, rx);
        bit_io(ak_out, ak_in);
    endtask
endmodule // i2c_master_model
`default_nettype wire
